// ==== inc/ucs_pkg.sv ====
package ucs_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] UCS_ADDR_CHK = 5'h00;
  localparam logic [4:0] UCS_ADDR_CFG = 5'h04;
  localparam logic [4:0] UCS_ADDR_EVT = 5'h08;
  localparam logic [4:0] UCS_ADDR_WB = 5'h0C;
  localparam logic [4:0] UCS_ADDR_CTRL = 5'h10;
  localparam logic [4:0] UCS_ADDR_TMR0 = 5'h14;
  localparam logic [4:0] UCS_ADDR_TMR_STEP = 5'h04;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UCS_CFG_RPT_LSB = 4;
  localparam int UCS_CFG_POLARITY_SELECT = 3;
  localparam int UCS_CFG_PD = 2;
  localparam int UCS_CFG_PRT = 1;
  localparam logic [15:0] UCS_CFG_MASK = 16'h003E;
  localparam int UCS_EVT_RXRPT = 5;
  localparam int UCS_EVT_TX_REPEAT_COUNT = 4;
  localparam int UCS_EVT_FLAG_LSB = 8;
  localparam logic [5:0] UCS_EVT_MASK = 6'h37;
  localparam int UCS_WB_WAKE = 7;
  localparam int UCS_WB_ABD = 6;
  localparam int UCS_WB_BAUD_DETECT_DONE_IRQ_ENABLE = 2;
  localparam int UCS_CTRL_MODE_LSB = 0;
  localparam int UCS_CTRL_INCL = 3;
  localparam int UCS_CTRL_WAKE = 4;
  localparam int UCS_CTRL_AUTO_BAUD_ENABLE = 5;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] UCS_CHK_RST = 8'h00;
  localparam logic [5:0] UCS_CFG_RST = 6'h00;
  localparam logic [2:0] UCS_RX_TRIES = 3'h5;
  localparam logic [2:0] UCS_ABD_EDGES = 3'h5;
  localparam int UCS_GT_W = 9;
  localparam int UCS_BT_W = 9;
  localparam int UCS_WT_W = 24;

  typedef enum logic [2:0] {
    UCS_MODE_ASYNC = 3'h0,
    UCS_MODE_LIN_CMD = 3'h1,
    UCS_MODE_LIN_RSP = 3'h2,
    UCS_MODE_LIN_BOTH = 3'h3,
    UCS_MODE_CARD = 3'h4
  } ucs_mode_t;

  typedef enum logic [1:0] {
    UCS_PD_IDLE = 2'b01,
    UCS_PD_PULL = 2'b10
  } ucs_pd_t;

endpackage : ucs_pkg

// ==== hw/ucs_core.sv ====
`timescale 1ns/1ps

// Overview of operation
// - LIN, identifier inclusion set: checksum sums all bytes with carries, identifier too.
// - LIN, identifier inclusion clear: checksum sums data bytes, skipping the identifier.
// - LIN responder and commander/responder: break clears the receive checksum.
// - Other modes: inclusion set adds every byte; cleared leaves checksum unchanged.
// - Errored card byte is resent once to four times per repeat field.
// - Convention bit one selects inverse logic, zero direct, for card characters.
// - T=0 error pulls the line low two ETU if bit set, else one.
// - Protocol bit one selects T=1, zero selects T=0.
// - Receive-repeat flag sets when parity fails on the fifth reception.
// - Transmit-repeat flag sets on line error after the last allowed resend.
// - Block, waiting and guard flags set when their counters reach zero.
// - Each card event interrupts only while its enable bit is one.
// - Hardware sets event flags; software reads them and clears them by writing one.
// - Wake enabled and receive line falling sets the wake flag and interrupts.
// - Final falling edge of baud detection sets the done flag.
// - Baud detection flag interrupts only while its enable bit is one.
// - Unimplemented bits read as zero.
// - Guard and block counters step once per ETU bit clock.
module ucs_core
  import ucs_pkg::*;
#(
  parameter int GT_W = UCS_GT_W,
  parameter int BT_W = UCS_BT_W,
  parameter int WT_W = UCS_WT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // received byte stream
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_is_pid,
  input wire logic break_det,
  input wire logic rx_pin,
  // card character events
  input wire logic etu_tick,
  input wire logic card_rx_done,
  input wire logic card_rx_parity_err,
  input wire logic card_tx_done,
  input wire logic card_tx_line_err,
  input wire logic [7:0] card_tx_data,
  // card side results
  output logic card_tx_retry,
  output logic [7:0] card_tx_line_data,
  output logic [7:0] card_rx_char,
  output logic card_rx_char_valid,
  output logic card_t1_mode,
  output logic line_out,
  output logic line_oe,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic ack_r;
  logic [7:0] chk_r;
  logic [5:0] cfg_r;
  logic [5:0] evt_en_r;
  logic [5:0] evt_flag_r;
  logic wake_flag_r;
  logic abd_flag_r;
  logic abd_ie_r;
  logic [2:0] mode_r;
  logic incl_r;
  logic wake_en_r;
  logic auto_baud_enable_r;
  logic [23:0] tmr_cnt_r [3];
  logic [2:0] tmr_hit;
  logic [2:0] rx_try_r;
  logic [2:0] tx_try_r;
  logic [2:0] abd_cnt_r;
  logic rx_s1_r, rx_s2_r, rx_s3_r;
  logic pd_left_r;
  ucs_pd_t pd_r;

  logic wr_en, rd_en, rx_fall, is_lin, brk_clr, card_t0;
  logic rx_perr_ev, tx_err_ev, rx_rpt_ev, tx_rpt_ev, abd_ev;
  logic [2:0] tx_limit;
  logic [7:0] chk_sum;
  logic [8:0] chk_wide;

  function automatic logic [7:0] ucs_polarity_select(input logic [7:0] d, input logic inv);
    logic [7:0] r;
    r = d;
    if (inv) begin
      for (int k = 0; k < 8; k++) begin
        r[k] = ~d[7 - k];
      end
    end
    return r;
  endfunction : ucs_polarity_select

  // ----------------------------------------------------------------
  // bus slave: one wait cycle on every access
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_en = avs_write & ack_r;
  assign rd_en = avs_read & ~ack_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_en) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address == UCS_ADDR_CHK) begin
        avs_readdata[7:0] <= chk_r;
      end else if (avs_address == UCS_ADDR_CFG) begin
        avs_readdata[6:1] <= cfg_r[5:0] & UCS_CFG_MASK[6:1];
      end else if (avs_address == UCS_ADDR_EVT) begin
        avs_readdata[13:8] <= evt_flag_r & UCS_EVT_MASK;
        avs_readdata[5:0] <= evt_en_r & UCS_EVT_MASK;
      end else if (avs_address == UCS_ADDR_WB) begin
        avs_readdata[UCS_WB_WAKE] <= wake_flag_r;
        avs_readdata[UCS_WB_ABD] <= abd_flag_r;
        avs_readdata[UCS_WB_BAUD_DETECT_DONE_IRQ_ENABLE] <= abd_ie_r;
      end else if (avs_address == UCS_ADDR_CTRL) begin
        avs_readdata[5:0] <= {auto_baud_enable_r, wake_en_r, incl_r, mode_r};
      end else if (avs_address == UCS_ADDR_TMR0) begin
        avs_readdata[23:0] <= tmr_cnt_r[0];
      end else if (avs_address == UCS_ADDR_TMR0 + UCS_ADDR_TMR_STEP) begin
        avs_readdata[23:0] <= tmr_cnt_r[1];
      end else if (avs_address == UCS_ADDR_TMR0 + 5'(2 * UCS_ADDR_TMR_STEP)) begin
        avs_readdata[23:0] <= tmr_cnt_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= UCS_CFG_RST;
      evt_en_r <= 6'h00;
      abd_ie_r <= 1'b0;
      mode_r <= UCS_MODE_ASYNC;
      incl_r <= 1'b0;
      wake_en_r <= 1'b0;
    end else if (wr_en) begin
      if (avs_address == UCS_ADDR_CFG) begin
        cfg_r <= avs_writedata[6:1];
      end else if (avs_address == UCS_ADDR_EVT) begin
        evt_en_r <= avs_writedata[5:0] & UCS_EVT_MASK;
      end else if (avs_address == UCS_ADDR_WB) begin
        abd_ie_r <= avs_writedata[UCS_WB_BAUD_DETECT_DONE_IRQ_ENABLE];
      end else if (avs_address == UCS_ADDR_CTRL) begin
        mode_r <= avs_writedata[UCS_CTRL_MODE_LSB +: 3];
        incl_r <= avs_writedata[UCS_CTRL_INCL];
        wake_en_r <= avs_writedata[UCS_CTRL_WAKE];
      end
    end
  end

  assign is_lin = (mode_r == UCS_MODE_LIN_CMD) | (mode_r == UCS_MODE_LIN_RSP) |
                  (mode_r == UCS_MODE_LIN_BOTH);
  assign card_t1_mode = cfg_r[UCS_CFG_PRT - 1];
  assign card_t0 = (mode_r == UCS_MODE_CARD) & ~card_t1_mode;

  // ----------------------------------------------------------------
  // receive checksum
  // ----------------------------------------------------------------
  assign brk_clr = break_det & ((mode_r == UCS_MODE_LIN_RSP) | (mode_r == UCS_MODE_LIN_BOTH));
  assign chk_wide = {1'b0, chk_r} + {1'b0, rx_byte};
  assign chk_sum = chk_wide[7:0] + {7'h00, chk_wide[8]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chk_r <= UCS_CHK_RST;
    end else if (brk_clr) begin
      chk_r <= UCS_CHK_RST;
    end else if (rx_byte_valid && is_lin && (incl_r || !rx_byte_is_pid)) begin
      chk_r <= chk_sum;
    end else if (rx_byte_valid && !is_lin && incl_r) begin
      chk_r <= chk_sum;
    end else if (wr_en && avs_address == UCS_ADDR_CHK) begin
      chk_r <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // card convention and character repeats
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      card_tx_line_data <= 8'h00;
      card_rx_char <= 8'h00;
      card_rx_char_valid <= 1'b0;
    end else begin
      card_tx_line_data <= ucs_polarity_select(card_tx_data, cfg_r[UCS_CFG_POLARITY_SELECT - 1]);
      card_rx_char_valid <= card_rx_done & (mode_r == UCS_MODE_CARD);
      if (card_rx_done) begin
        card_rx_char <= ucs_polarity_select(rx_byte, cfg_r[UCS_CFG_POLARITY_SELECT - 1]);
      end
    end
  end

  assign rx_perr_ev = card_t0 & card_rx_done & card_rx_parity_err;
  assign rx_rpt_ev = rx_perr_ev & (rx_try_r == UCS_RX_TRIES - 3'h1);
  assign tx_limit = {1'b0, cfg_r[UCS_CFG_RPT_LSB - 1 +: 2]} + 3'h1;
  assign tx_err_ev = card_t0 & card_tx_line_err;
  assign tx_rpt_ev = tx_err_ev & (tx_try_r == tx_limit);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_try_r <= 3'h0;
    end else if (rx_rpt_ev || (card_rx_done && !card_rx_parity_err)) begin
      rx_try_r <= 3'h0;
    end else if (rx_perr_ev) begin
      rx_try_r <= rx_try_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_try_r <= 3'h0;
      card_tx_retry <= 1'b0;
    end else begin
      card_tx_retry <= tx_err_ev & (tx_try_r != tx_limit);
      if (tx_rpt_ev || (card_tx_done && !card_tx_line_err)) begin
        tx_try_r <= 3'h0;
      end else if (tx_err_ev) begin
        tx_try_r <= tx_try_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // T=0 error pull-down
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_r <= UCS_PD_IDLE;
      pd_left_r <= 1'b0;
    end else begin
      case (pd_r)
        UCS_PD_IDLE: begin
          if (rx_perr_ev) begin
            pd_r <= UCS_PD_PULL;
            pd_left_r <= cfg_r[UCS_CFG_PD - 1];
          end
        end
        UCS_PD_PULL: begin
          if (etu_tick) begin
            pd_left_r <= 1'b0;
            if (!pd_left_r) begin
              pd_r <= UCS_PD_IDLE;
            end
          end
        end
        default: begin
          pd_r <= UCS_PD_IDLE;
        end
      endcase
    end
  end

  assign line_out = 1'b0;
  assign line_oe = (pd_r == UCS_PD_PULL);

  // ----------------------------------------------------------------
  // guard, waiting and block counters on the ETU clock
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    localparam int W = (i == 0) ? GT_W : (i == 1) ? WT_W : BT_W;
    localparam logic [23:0] MSK = 24'((64'h1 << W) - 64'h1);
    localparam logic [4:0] ADR = UCS_ADDR_TMR0 + 5'(i * 4);
    assign tmr_hit[i] = etu_tick & (mode_r == UCS_MODE_CARD) & (tmr_cnt_r[i] == 24'h000001);
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tmr_cnt_r[i] <= 24'h000000;
      end else if (wr_en && avs_address == ADR) begin
        tmr_cnt_r[i] <= avs_writedata[23:0] & MSK;
      end else if (etu_tick && mode_r == UCS_MODE_CARD && tmr_cnt_r[i] != 24'h000000) begin
        tmr_cnt_r[i] <= tmr_cnt_r[i] - 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // card event flags: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_flag_r <= 6'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (wr_en && avs_address == UCS_ADDR_EVT && avs_writedata[UCS_EVT_FLAG_LSB + k]) begin
          evt_flag_r[k] <= 1'b0;
        end
      end
      if (rx_rpt_ev) begin
        evt_flag_r[UCS_EVT_RXRPT] <= 1'b1;
      end
      if (tx_rpt_ev) begin
        evt_flag_r[UCS_EVT_TX_REPEAT_COUNT] <= 1'b1;
      end
      for (int k = 0; k < 3; k++) begin
        if (tmr_hit[k]) begin
          evt_flag_r[k] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wake-up and auto-baud detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  assign rx_fall = rx_s3_r & ~rx_s2_r;
  assign abd_ev = auto_baud_enable_r & rx_fall & (abd_cnt_r == UCS_ABD_EDGES - 3'h1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_baud_enable_r <= 1'b0;
      abd_cnt_r <= 3'h0;
    end else if (abd_ev) begin
      auto_baud_enable_r <= 1'b0;
      abd_cnt_r <= 3'h0;
    end else if (wr_en && avs_address == UCS_ADDR_CTRL) begin
      auto_baud_enable_r <= avs_writedata[UCS_CTRL_AUTO_BAUD_ENABLE];
      abd_cnt_r <= 3'h0;
    end else if (auto_baud_enable_r && rx_fall) begin
      abd_cnt_r <= abd_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_flag_r <= 1'b0;
      abd_flag_r <= 1'b0;
    end else begin
      if (wake_en_r && rx_fall) begin
        wake_flag_r <= 1'b1;
      end else if (wr_en && avs_address == UCS_ADDR_WB && avs_writedata[UCS_WB_WAKE]) begin
        wake_flag_r <= 1'b0;
      end
      if (abd_ev) begin
        abd_flag_r <= 1'b1;
      end else if (wr_en && avs_address == UCS_ADDR_WB && avs_writedata[UCS_WB_ABD]) begin
        abd_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  assign irq = (|(evt_flag_r & evt_en_r)) | wake_flag_r | (abd_flag_r & abd_ie_r);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_chk_break;
    brk_clr |=> chk_r == 8'h00;
  endproperty
  a_chk_break: assert property (p_chk_break) else $error("break did not clear checksum");

  property p_chk_pid_skip;
    rx_byte_valid && is_lin && !incl_r && rx_byte_is_pid && !brk_clr |=> $stable(chk_r);
  endproperty
  a_chk_pid_skip: assert property (p_chk_pid_skip) else $error("identifier summed");

  property p_chk_add;
    rx_byte_valid && incl_r && !brk_clr |=>
      chk_r == 8'(($past(chk_r) + $past(rx_byte)) % 9'h0FF) ||
      (chk_r == 8'hFF && (9'($past(chk_r)) + 9'($past(rx_byte))) % 9'h0FF == 9'h000
       && ($past(chk_r) | $past(rx_byte)) != 8'h00);
  endproperty
  a_chk_add: assert property (p_chk_add) else $error("checksum sum wrong");

  property p_chk_off;
    rx_byte_valid && !is_lin && !incl_r && !wr_en |=> $stable(chk_r);
  endproperty
  a_chk_off: assert property (p_chk_off) else $error("checksum moved when off");

  property p_tx_flag;
    tx_err_ev && tx_try_r == tx_limit |=> evt_flag_r[UCS_EVT_TX_REPEAT_COUNT] && !card_tx_retry;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx repeat flag missing");

  property p_tx_retry;
    tx_err_ev && tx_try_r < tx_limit |=> card_tx_retry ##1 !card_tx_retry;
  endproperty
  a_tx_retry: assert property (p_tx_retry) else $error("retransmit not requested");

  property p_rx_flag;
    rx_perr_ev && rx_try_r == 3'h4 |=> evt_flag_r[UCS_EVT_RXRPT] && rx_try_r == 3'h0;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("rx repeat flag missing");

  property p_pull_len;
    line_oe && etu_tick |=> line_oe == $past(pd_left_r);
  endproperty
  a_pull_len: assert property (p_pull_len) else $error("pull-down too long");

  property p_pull_load;
    pd_r == UCS_PD_IDLE && rx_perr_ev && cfg_r[UCS_CFG_PD - 1] |=> line_oe && pd_left_r;
  endproperty
  a_pull_load: assert property (p_pull_load) else $error("two ETU pull-down not armed");

  property p_t1_quiet;
    card_t1_mode && pd_r == UCS_PD_IDLE |=> !line_oe;
  endproperty
  a_t1_quiet: assert property (p_t1_quiet) else $error("pull-down in T=1");

  property p_tmr_flag;
    tmr_hit[0] |=> evt_flag_r[0] && tmr_cnt_r[0] == 24'h000000;
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("guard flag missing");

  property p_abd_mask;
    abd_flag_r && !abd_ie_r && !wake_flag_r && (evt_flag_r & evt_en_r) == 6'h00 |-> !irq;
  endproperty
  a_abd_mask: assert property (p_abd_mask) else $error("masked baud irq");

  property p_wake;
    wake_en_r && rx_fall |=> wake_flag_r && irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag missing");

  c_pid_skip: cover property (rx_byte_valid && is_lin && rx_byte_is_pid && !incl_r);
  c_tx_rpt: cover property (tx_rpt_ev);
  c_rx_rpt: cover property (rx_rpt_ev);
  c_abd: cover property (abd_ev ##1 irq);

endmodule : ucs_core

// ==== tb/ucs_far_model.sv ====
`timescale 1ns/1ps
module ucs_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // line and card side
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_byte_is_pid,
  output logic break_det,
  output logic rx_pin,
  output logic etu_tick,
  output logic card_rx_done,
  output logic card_rx_parity_err,
  output logic card_tx_done,
  output logic card_tx_line_err
);
  logic [2:0] div_r;
  initial {rx_byte_valid, rx_byte, rx_byte_is_pid, break_det, etu_tick} = '0;
  initial {card_rx_done, card_rx_parity_err, card_tx_done, card_tx_line_err} = '0;
  initial rx_pin = 1'b1;
  // ------------------------------------------------------------
  // bit clock: one tick per elementary time unit
  // ------------------------------------------------------------
  always @(posedge clk) begin
    div_r <= sys_rst ? 3'h0 : div_r + 3'h1;
    etu_tick <= div_r == 3'h7;
  end
  // released data shows the inverse, not the last value
  task automatic put_byte(input logic [7:0] b, input logic pid);
    rx_byte <= b;
    rx_byte_is_pid <= pid;
    rx_byte_valid <= 1'b1;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    rx_byte_is_pid <= !pid;
    @(posedge clk);
  endtask : put_byte
  task automatic brk();
    break_det <= 1'b1;
    @(posedge clk);
    break_det <= 1'b0;
    @(posedge clk);
  endtask : brk
  task automatic card_rx(input logic perr);
    card_rx_parity_err <= perr;
    card_rx_done <= 1'b1;
    @(posedge clk);
    card_rx_done <= 1'b0;
    card_rx_parity_err <= !perr;
    repeat (2) @(posedge clk);
  endtask : card_rx
  task automatic card_tx(input logic err);
    card_tx_line_err <= err;
    card_tx_done <= !err;
    @(posedge clk);
    card_tx_line_err <= 1'b0;
    card_tx_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : card_tx
  task automatic line_fall();
    rx_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rx_pin <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : line_fall
endmodule : ucs_far_model

// ==== tb/ucs_core_test.sv ====
`timescale 1ns/1ps
module ucs_core_test import ucs_pkg::*;;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic rx_byte_valid, rx_byte_is_pid, break_det, rx_pin, etu_tick;
  logic card_rx_done, card_rx_parity_err, card_tx_done, card_tx_line_err;
  logic [7:0] rx_byte, card_tx_data, card_tx_line_data, card_rx_char;
  logic card_tx_retry, card_t1_mode, line_oe, irq, line_out, card_rx_char_valid;
  int errors, n_checks, n_retry, n_pd, n_rxc;
  ucs_core dut (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rx_byte_valid, .rx_byte, .rx_byte_is_pid, .break_det, .rx_pin,
    .etu_tick, .card_rx_done, .card_rx_parity_err, .card_tx_done, .card_tx_line_err,
    .card_tx_data, .card_tx_retry, .card_tx_line_data, .card_rx_char,
    .card_rx_char_valid, .card_t1_mode, .line_out, .line_oe, .irq
  );
  ucs_far_model far (
    .clk, .sys_rst, .rx_byte_valid, .rx_byte, .rx_byte_is_pid, .break_det, .rx_pin,
    .etu_tick, .card_rx_done, .card_rx_parity_err, .card_tx_done, .card_tx_line_err
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (card_tx_retry === 1'b1) n_retry++;
    if (line_oe === 1'b1 && etu_tick === 1'b1) n_pd++;
    if (card_rx_char_valid === 1'b1) n_rxc++;
  end
  // ------------------------------------------------------------
  // bus access and checking
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask : rc
  task automatic ci(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ci
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {errors, n_checks, n_retry, n_pd} = '0;
    {sys_rst, avs_address, avs_read, avs_write, avs_writedata} = {1'b1, 39'h0};
    card_tx_data = 8'h03;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rc(5'(i * 4), 32'h0);
    rc(5'h02, 32'h0);
    wr(UCS_ADDR_CFG, 32'hFFFFFFFF);
    rc(UCS_ADDR_CFG, 32'h3E);
    wr(UCS_ADDR_EVT, 32'hFFFFFFFF);
    rc(UCS_ADDR_EVT, 32'h37);
    wr(UCS_ADDR_WB, 32'hFFFFFFFF);
    rc(UCS_ADDR_WB, 32'h04);
    wr(UCS_ADDR_WB, 32'h0);
    wr(UCS_ADDR_EVT, 32'h0);
    wr(UCS_ADDR_CFG, 32'h0);
    wr(UCS_ADDR_CTRL, 32'h09);
    far.put_byte(8'h80, 1'b1);
    far.put_byte(8'h90, 1'b0);
    rc(UCS_ADDR_CHK, 32'h11);
    wr(UCS_ADDR_CHK, 32'h0);
    wr(UCS_ADDR_CTRL, 32'h01);
    far.put_byte(8'h80, 1'b1);
    far.put_byte(8'h90, 1'b0);
    far.put_byte(8'h70, 1'b0);
    rc(UCS_ADDR_CHK, 32'h01);
    wr(UCS_ADDR_CTRL, 32'h02);
    far.brk();
    rc(UCS_ADDR_CHK, 32'h0);
    wr(UCS_ADDR_CTRL, 32'h03);
    far.put_byte(8'h55, 1'b0);
    far.brk();
    rc(UCS_ADDR_CHK, 32'h0);
    wr(UCS_ADDR_CTRL, 32'h00);
    wr(UCS_ADDR_CHK, 32'h33);
    far.put_byte(8'h42, 1'b0);
    rc(UCS_ADDR_CHK, 32'h33);
    wr(UCS_ADDR_CTRL, 32'h08);
    far.put_byte(8'h42, 1'b0);
    rc(UCS_ADDR_CHK, 32'h75);
    wr(UCS_ADDR_CTRL, 32'h04);
    wr(UCS_ADDR_CFG, 32'h08);
    @(posedge clk);
    chk({24'h0, card_tx_line_data}, 32'h3F);
    card_tx_data <= 8'h01;
    repeat (2) @(posedge clk);
    chk({24'h0, card_tx_line_data}, 32'h7F);
    wr(UCS_ADDR_CFG, 32'h0);
    @(posedge clk);
    chk({24'h0, card_tx_line_data}, 32'h01);
    for (int r = 0; r < 4; r++) begin
      wr(UCS_ADDR_CFG, 32'(r) << UCS_CFG_RPT_LSB);
      n_retry = 0;
      repeat (r + 2) far.card_tx(1'b1);
      chk(32'(n_retry), 32'(r + 1));
      rc(UCS_ADDR_EVT, 32'h1000);
      wr(UCS_ADDR_EVT, 32'h1000);
      far.card_tx(1'b0);
    end
    wr(UCS_ADDR_CFG, 32'h02);
    chk({31'h0, card_t1_mode}, 32'h1);
    n_retry = 0;
    repeat (2) far.card_tx(1'b1);
    chk(32'(n_retry), 32'h0);
    rc(UCS_ADDR_EVT, 32'h0);
    wr(UCS_ADDR_CFG, 32'h0);
    n_rxc = 0;
    repeat (4) far.card_rx(1'b1);
    rc(UCS_ADDR_EVT, 32'h0);
    far.card_rx(1'b1);
    rc(UCS_ADDR_EVT, 32'h2000);
    chk(32'(n_rxc), 32'h5);
    chk({24'h0, card_rx_char}, 32'hBD);
    wr(UCS_ADDR_EVT, 32'h2000);
    for (int p = 1; p >= 0; p--) begin
      wr(UCS_ADDR_CFG, 32'(p) << UCS_CFG_PD);
      far.card_rx(1'b0);
      n_pd = 0;
      far.card_rx(1'b1);
      chk({31'h0, line_out}, 32'h0);
      repeat (40) @(posedge clk);
      chk(32'(n_pd), 32'(p + 1));
    end
    far.card_rx(1'b0);
    wr(UCS_ADDR_TMR0, 32'h4);
    wr(UCS_ADDR_TMR0 + UCS_ADDR_TMR_STEP, 32'h3);
    wr(UCS_ADDR_TMR0 + UCS_ADDR_TMR_STEP + UCS_ADDR_TMR_STEP, 32'h3);
    rc(UCS_ADDR_EVT, 32'h0);
    repeat (48) @(posedge clk);
    rc(UCS_ADDR_EVT, 32'h0700);
    ci(1'b0);
    wr(UCS_ADDR_EVT, 32'h04);
    ci(1'b1);
    wr(UCS_ADDR_EVT, 32'h0704);
    ci(1'b0);
    wr(UCS_ADDR_CTRL, 32'h10);
    far.line_fall();
    rc(UCS_ADDR_WB, 32'h80);
    ci(1'b1);
    wr(UCS_ADDR_WB, 32'h80);
    ci(1'b0);
    wr(UCS_ADDR_CTRL, 32'h20);
    repeat (5) far.line_fall();
    rc(UCS_ADDR_WB, 32'h40);
    rc(UCS_ADDR_CTRL, 32'h0);
    ci(1'b0);
    wr(UCS_ADDR_WB, 32'h04);
    ci(1'b1);
    wr(UCS_ADDR_WB, 32'h44);
    ci(1'b0);
    report_and_stop();
  end
endmodule : ucs_core_test
